// ==== rtl/dac_cmd_consts.svh ====
// Purpose: Constants of the serial command decoder.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef DAC_CMD_CONSTS_SVH
`define DAC_CMD_CONSTS_SVH

// --------------------------------------------------------------
// Frame and word layout
// --------------------------------------------------------------
`define FRAME_BITS      5'h18
`define FRAME_OVER      5'h19
`define CH_COUNT        40
`define DATA_W          14
`define BANK_W          8
`define GROUPS          5

// --------------------------------------------------------------
// Address decode
// --------------------------------------------------------------
`define ADDR_UP_ALL     3'h0
`define ADDR_GRP_LAST   3'h5
`define ADDR_SAME_ALL   3'h6

// --------------------------------------------------------------
// Special function codes
// --------------------------------------------------------------
`define FN_NOP          6'h00
`define FN_CTRL         6'h01
`define FN_OFFSET_DAC_0         6'h02
`define FN_OFFSET_DAC_1         6'h03
`define FN_OFFSET_DAC_2         6'h04
`define FN_RDSEL        6'h05
`define FN_BANK0        6'h06
`define FN_BANK4        6'h0a
`define FN_BANK_ALL     6'h0b

// --------------------------------------------------------------
// Control bits and readback codes
// --------------------------------------------------------------
`define CTRL_BANK_BIT   2
`define CTRL_TSD_BIT    1
`define CTRL_PWDN_BIT   0
`define RB_SPECIAL      3'h4
`define RB_CH_BASE      6'h08
`define RB_CH_LAST      6'h2f
`define RB_CTRL         6'h01
`define RB_OFFSET_DAC_0         6'h02
`define RB_OFFSET_DAC_1         6'h03
`define RB_OFFSET_DAC_2         6'h04
`define RB_BANK0        6'h06

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_INPUT       14'h0000
`define RST_OFFSET      14'h2000
`define RST_GAIN        14'h3fff
`define RST_OFSDAC      14'h0000
`define RST_BANK        8'h00

`endif

// ==== rtl/dac_cmd_pkg.sv ====
// Purpose: Types of the serial command decoder.
// Assumes: Nothing.
// Notes:   Constants live in the header.
package dac_cmd_pkg;

	typedef enum logic [1:0] {
		MODE_SPECIAL = 2'b00,
		MODE_GAIN    = 2'b01,
		MODE_OFFSET  = 2'b10,
		MODE_INPUT   = 2'b11
	} mode_t;

	typedef enum logic [1:0] {
		RB_IDLE  = 2'b00,
		RB_ARMED = 2'b01,
		RB_SHIFT = 2'b10
	} rb_state_t;

	typedef struct packed {
		mode_t       mode;
		logic [5:0]  addr;
		logic [13:0] data;
		logic [1:0]  rsvd;
	} cmd_t;

	typedef struct packed {
		logic [1:0]  mode;
		logic [5:0]  func;
		logic [15:0] operand;
	} sf_t;

	typedef struct packed {
		logic overtemp;
		logic rsvd;
		logic bank_sel;
		logic tsd_en;
		logic pwdn;
	} ctrl_t;

endpackage

// ==== rtl/dac_serial_command_decoder.sv ====
// Purpose: Serial command decoder with channel, offset and select registers.
// Assumes: Link clock stops outside frames; data taken on its falling edge.
// Notes:   Frame words are read across domains only while the link is idle.
`timescale 1ns/100ps
`include "dac_cmd_consts.svh"

// Behaviour
// - Nonzero mode writes data to addressed channels.
// - Input write goes to bank per control bit.
// - Mode 11 input, 10 offset, 01 gain, 00 special.
// - Upper 000: all channels or one group.
// - Upper 001-101: single channel of group minus one.
// - Upper 110: same channel in all groups.
// - Upper 111: same channel in groups 1-4.
// - Special: bits 21-16 function, low 16 operand.
// - Control operand bit 2 selects input bank.
// - Control operand bit 1 enables thermal shutdown.
// - Control operand bit 0 powers down.
// - Control bit 4 is read-only overtemperature flag.
// - Codes 2-4 load offset DAC registers 0-2.
// - Code 5 records the readback selection.
// - Codes 6-10 load bank select registers 0-4.
// - Code 11 writes all bank select registers.
// - Word is 24 bits, most significant first.
// - Selected register shifts out on next frame.
// - Writes take effect only after complete frame.
module dac_serial_command_decoder
	import dac_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic                              ref_clk_in,
	input  wire logic                              resetn_in,
	// Serial link
	input  wire logic                              sclk_in,
	input  wire logic                              sync_n_in,
	input  wire logic                              serial_in_in,
	output logic                                   serial_out_out,
	output logic                                   serial_out_oe_out,
	// Status input
	input  wire logic                              overtemp_in,
	// Channel registers
	output logic [`CH_COUNT-1:0][`DATA_W-1:0]      input_bank_first_out,
	output logic [`CH_COUNT-1:0][`DATA_W-1:0]      input_bank_second_out,
	output logic [`CH_COUNT-1:0][`DATA_W-1:0]      offset_reg_out,
	output logic [`CH_COUNT-1:0][`DATA_W-1:0]      gain_reg_out,
	// Device registers
	output ctrl_t                                  device_control_out,
	output logic [`DATA_W-1:0]                     offset_dac_0_out,
	output logic [`DATA_W-1:0]                     offset_dac_1_out,
	output logic [`DATA_W-1:0]                     offset_dac_2_out,
	output logic [`GROUPS-1:0][`BANK_W-1:0]        bank_select_out
);

	// ----------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------
	logic                                 started_q;
	logic [4:0]                           cnt_q;
	logic [23:0]                          rx_q;
	logic [23:0]                          tx_q;
	logic                                 sdo_q;
	logic [2:0]                           sy_q;
	logic [2:0]                           ot_q;
	logic                                 frm_hi_q;
	logic                                 frame_end;
	logic                                 frame_start;
	logic                                 commit;
	logic                                 commit_d_q;
	cmd_t                                 cmd;
	sf_t                                  sf;
	logic                                 is_data;
	logic                                 is_sf;
	logic [`CH_COUNT-1:0]                 ch_sel;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]    x1a_q;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]    x1b_q;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]    offs_q;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]    gain_q;
	ctrl_t                                ctrl_q;
	logic [`DATA_W-1:0]                   offset_dac_0_q;
	logic [`DATA_W-1:0]                   offset_dac_1_q;
	logic [`DATA_W-1:0]                   offset_dac_2_q;
	logic [`GROUPS-1:0][`BANK_W-1:0]      bank_q;
	logic [15:0]                          rb_sel_q;
	logic [15:0]                          rb_val;
	logic [5:0]                           rb_ch;
	logic [23:0]                          rb_word_q;
	rb_state_t                            rb_d;
	rb_state_t                            rb_q;
	logic                                 oe_q;

	// ----------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------
	// The frame signal itself ends the frame, since the link clock
	// may not tick again after the last bit.
	always_ff @(negedge sclk_in or negedge resetn_in or posedge sync_n_in) begin
		if (!resetn_in || sync_n_in) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	// Count saturates one past a full word so that an overlong frame
	// is recognised as corrupt and dropped.
	always_ff @(negedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= 5'h00;
		end else if (!sync_n_in) begin
			if (!started_q) begin
				cnt_q <= 5'h01;
			end else if (cnt_q != `FRAME_OVER) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	always_ff @(negedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_q <= 24'h000000;
		end else if (!sync_n_in) begin
			rx_q <= {rx_q[22:0], serial_in_in};
		end
	end

	// The readback word only changes between frames, so it is steady
	// whenever the link clock samples it.
	always_ff @(negedge sclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_q  <= 24'h000000;
			sdo_q <= 1'b0;
		end else if (!sync_n_in) begin
			if (!started_q) begin
				tx_q  <= {rb_word_q[22:0], 1'b0};
				sdo_q <= rb_word_q[23];
			end else begin
				tx_q  <= {tx_q[22:0], 1'b0};
				sdo_q <= tx_q[23];
			end
		end
	end

	// ----------------------------------------------------------
	// Frame detection
	// ----------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sy_q     <= 3'h7;
			ot_q     <= 3'h0;
			frm_hi_q <= 1'b1;
		end else begin
			sy_q <= {sy_q[1:0], sync_n_in};
			ot_q <= {ot_q[1:0], overtemp_in};
			if (sy_q[1] == sy_q[2]) begin
				frm_hi_q <= sy_q[2];
			end
		end
	end

	assign frame_end   = sy_q[1] && sy_q[2] && !frm_hi_q;
	assign frame_start = !sy_q[1] && !sy_q[2] && frm_hi_q;
	assign commit      = frame_end && (cnt_q == `FRAME_BITS);
	assign cmd         = cmd_t'(rx_q);
	assign sf          = sf_t'(rx_q);
	assign is_data     = commit && (cmd.mode != MODE_SPECIAL);
	assign is_sf       = commit && (cmd.mode == MODE_SPECIAL);

	// ----------------------------------------------------------
	// Channel addressing
	// ----------------------------------------------------------
	for (genvar i = 0; i < `CH_COUNT; i++) begin : g_sel
		localparam logic [2:0] GRP = 3'(i / 8);
		localparam logic [2:0] CH  = 3'(i % 8);
		logic [2:0] up;
		logic [2:0] lo;
		assign up = cmd.addr[5:3];
		assign lo = cmd.addr[2:0];
		assign ch_sel[i] =
			(up == `ADDR_UP_ALL)   ? (lo == 3'h0 || lo == GRP + 3'h1) :
			(up <= `ADDR_GRP_LAST) ? (up == GRP + 3'h1 && lo == CH)   :
			(up == `ADDR_SAME_ALL) ? (lo == CH)                       :
			(lo == CH && GRP != 3'h0);
	end

	// One loop serves every addressing form, so a group write
	// is per channel exactly a single write.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `CH_COUNT; i++) begin
				x1a_q[i]  <= `RST_INPUT;
				x1b_q[i]  <= `RST_INPUT;
				offs_q[i] <= `RST_OFFSET;
				gain_q[i] <= `RST_GAIN;
			end
		end else if (is_data) begin
			for (int i = 0; i < `CH_COUNT; i++) begin
				if (ch_sel[i]) begin
					case (cmd.mode)
						MODE_INPUT: begin
							if (ctrl_q.bank_sel) begin
								x1b_q[i] <= cmd.data;
							end else begin
								x1a_q[i] <= cmd.data;
							end
						end
						MODE_OFFSET: begin
							offs_q[i] <= cmd.data;
						end
						MODE_GAIN: begin
							gain_q[i] <= cmd.data;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------
	// Special functions
	// ----------------------------------------------------------
	// Unlisted codes fall to the default branch; there only codes 6-10 load a bank select register.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_q   <= ctrl_t'(5'h00);
			offset_dac_0_q   <= `RST_OFSDAC;
			offset_dac_1_q   <= `RST_OFSDAC;
			offset_dac_2_q   <= `RST_OFSDAC;
			bank_q   <= {`GROUPS{`RST_BANK}};
			rb_sel_q <= 16'h0000;
		end else begin
			if (ot_q[2] == ot_q[1]) ctrl_q.overtemp <= ot_q[2];
			if (is_sf) begin
				case (sf.func)
					`FN_CTRL: begin
						ctrl_q.bank_sel <= sf.operand[`CTRL_BANK_BIT];
						ctrl_q.tsd_en   <= sf.operand[`CTRL_TSD_BIT];
						ctrl_q.pwdn     <= sf.operand[`CTRL_PWDN_BIT];
					end
					`FN_OFFSET_DAC_0: offset_dac_0_q <= sf.operand[13:0];
					`FN_OFFSET_DAC_1: offset_dac_1_q <= sf.operand[13:0];
					`FN_OFFSET_DAC_2: offset_dac_2_q <= sf.operand[13:0];
					`FN_RDSEL: rb_sel_q <= sf.operand;
					`FN_BANK_ALL: bank_q <= {`GROUPS{sf.operand[7:0]}};
					default: begin
						if (sf.func >= `FN_BANK0 && sf.func <= `FN_BANK4) begin
							bank_q[3'(sf.func - `FN_BANK0)] <= sf.operand[7:0];
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------
	// Readback
	// ----------------------------------------------------------
	assign rb_ch = rb_sel_q[12:7] - `RB_CH_BASE;

	always_comb begin
		rb_val = 16'h0000;
		if (rb_sel_q[15:13] == `RB_SPECIAL) begin
			case (rb_sel_q[12:7])
				`RB_CTRL: rb_val = {11'h000, ctrl_q.overtemp, 1'b0, ctrl_q[2:0]};
				`RB_OFFSET_DAC_0: rb_val = {2'h0, offset_dac_0_q};
				`RB_OFFSET_DAC_1: rb_val = {2'h0, offset_dac_1_q};
				`RB_OFFSET_DAC_2: rb_val = {2'h0, offset_dac_2_q};
				default: begin
					if (rb_sel_q[12:7] >= `RB_BANK0 && rb_sel_q[12:7] < `RB_BANK0 + 6'h05) begin
						rb_val = {8'h00, bank_q[3'(rb_sel_q[12:7] - `RB_BANK0)]};
					end
				end
			endcase
		end else if (rb_sel_q[15:13] < `RB_SPECIAL && rb_sel_q[12:7] >= `RB_CH_BASE
				&& rb_sel_q[12:7] <= `RB_CH_LAST) begin
			case (rb_sel_q[14:13])
				2'h0: rb_val = {2'h0, x1a_q[rb_ch]};
				2'h1: rb_val = {2'h0, x1b_q[rb_ch]};
				2'h2: rb_val = {2'h0, offs_q[rb_ch]};
				default: rb_val = {2'h0, gain_q[rb_ch]};
			endcase
		end
	end

	// The word is refreshed once, just after each accepted frame, so it
	// stays still while the link may be reading it.
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			commit_d_q <= 1'b0;
			rb_word_q  <= 24'h000000;
		end else begin
			commit_d_q <= commit;
			if (commit_d_q) begin
				rb_word_q <= {8'h00, rb_val};
			end
		end
	end

	always_comb begin
		rb_d = rb_q;
		case (rb_q)
			RB_IDLE: if (is_sf && sf.func == `FN_RDSEL) rb_d = RB_ARMED;
			RB_ARMED: if (frame_start) rb_d = RB_SHIFT;
			RB_SHIFT: begin
				if (frame_end) begin
					rb_d = (is_sf && sf.func == `FN_RDSEL) ? RB_ARMED : RB_IDLE;
				end
			end
			default: rb_d = RB_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rb_q <= RB_IDLE;
			oe_q <= 1'b0;
		end else begin
			rb_q <= rb_d;
			oe_q <= (rb_d != RB_IDLE);
		end
	end

	// ----------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------
	assign serial_out_out        = sdo_q;
	assign serial_out_oe_out     = oe_q;
	assign input_bank_first_out  = x1a_q;
	assign input_bank_second_out = x1b_q;
	assign offset_reg_out        = offs_q;
	assign gain_reg_out          = gain_q;
	assign device_control_out    = ctrl_q;
	assign offset_dac_0_out      = offset_dac_0_q;
	assign offset_dac_1_out      = offset_dac_1_q;
	assign offset_dac_2_out      = offset_dac_2_q;
	assign bank_select_out       = bank_q;

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	AST_WRITE_NEEDS_FRAME: assert property (
		!$stable(gain_q) |-> $past(commit)
	) else $error("Gain changed without a complete frame.");

	AST_SPECIAL_SPARES_CH: assert property (
		is_sf |=> $stable(gain_q) && $stable(offs_q) && $stable(x1a_q)
	) else $error("Special function touched a channel.");

	AST_BANK_FIRST_ONLY: assert property (
		is_data && cmd.mode == MODE_INPUT && !ctrl_q.bank_sel |=> $stable(x1b_q)
	) else $error("Second bank written while first selected.");

	AST_BROADCAST_ALL: assert property (
		is_data && cmd.mode == MODE_GAIN && cmd.addr == 6'h00
		|=> gain_q[39] == $past(cmd.data) && gain_q[0] == $past(cmd.data)
	) else $error("Broadcast missed a channel.");

	AST_SINGLE_CH: assert property (
		is_data && cmd.mode == MODE_OFFSET && cmd.addr == 6'h13
		|=> offs_q[11] == $past(cmd.data) && $stable(offs_q[10:0])
	) else $error("Single channel write misplaced.");

	AST_SAME_ALL: assert property (
		is_data && cmd.mode == MODE_GAIN && cmd.addr == 6'h32
		|=> gain_q[2] == $past(cmd.data) && gain_q[34] == $past(cmd.data)
	) else $error("Same channel write missed a group.");

	AST_SKIP_GROUP0: assert property (
		is_data && cmd.addr[5:3] == 3'h7 |=> $stable(gain_q[7:0]) && $stable(offs_q[7:0])
	) else $error("Group zero written by groups 1-4 form.");

	AST_OFS_LOAD: assert property (
		is_sf && sf.func == `FN_OFFSET_DAC_1 |=> offset_dac_1_q == $past(sf.operand[13:0])
	) else $error("Offset DAC register not loaded.");

	AST_CTRL_LOAD: assert property (
		is_sf && sf.func == `FN_CTRL |=> ctrl_q[2:0] == $past(sf.operand[2:0])
	) else $error("Control bits not loaded.");

	AST_BLOCK_BANK: assert property (
		is_sf && sf.func == `FN_BANK_ALL |=> bank_q[4] == $past(sf.operand[7:0])
		&& bank_q[0] == $past(sf.operand[7:0])
	) else $error("Block select write incomplete.");

	AST_NOP_QUIET: assert property (
		is_sf && sf.func == `FN_NOP |=> $stable(bank_q) && $stable(offset_dac_0_q) && $stable(rb_sel_q)
	) else $error("No-operation changed a register.");

	AST_READ_DRIVES: assert property (
		is_sf && sf.func == `FN_RDSEL |=> oe_q ##1 rb_word_q[15:0] == $past(rb_val)
	) else $error("Readback not armed.");

endmodule // dac_serial_command_decoder

// ==== verif/dac_serial_command_decoder_tb.sv ====
// Purpose: Self-checking bench of the serial command decoder.
// Assumes: Registers settle within the host's idle gap after each frame.
// Notes:   Expected state is rebuilt here from the decode rules.
`timescale 1ns/100ps
`include "dac_cmd_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module dac_serial_command_decoder_tb;
	import dac_cmd_pkg::*;

	logic                                ref_clk_in;
	logic                                resetn_in;
	logic                                overtemp_in;
	logic                                sclk;
	logic                                sync_n;
	logic                                serial_in;
	logic                                serial_out;
	logic                                serial_oe;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]   bank_first, bank_second, ofs_reg, gain_reg;
	logic [`CH_COUNT-1:0][`DATA_W-1:0]   e_first, e_second, e_ofs, e_gain;
	ctrl_t                               ctrl, e_ctrl;
	logic [`DATA_W-1:0]                  odac0, odac1, odac2;
	logic [`DATA_W-1:0]                  e_odac [3];
	logic [`GROUPS-1:0][`BANK_W-1:0]     bank_sel, e_bank;
	logic [23:0]                         rd;
	int                                  err_total, samples_checked, pause;

	dac_serial_command_decoder i_dac_serial_command_decoder (
		.ref_clk_in            (ref_clk_in),
		.resetn_in             (resetn_in),
		.sclk_in               (sclk),
		.sync_n_in             (sync_n),
		.serial_in_in          (serial_in),
		.serial_out_out        (serial_out),
		.serial_out_oe_out     (serial_oe),
		.overtemp_in           (overtemp_in),
		.input_bank_first_out  (bank_first),
		.input_bank_second_out (bank_second),
		.offset_reg_out        (ofs_reg),
		.gain_reg_out          (gain_reg),
		.device_control_out    (ctrl),
		.offset_dac_0_out      (odac0),
		.offset_dac_1_out      (odac1),
		.offset_dac_2_out      (odac2),
		.bank_select_out       (bank_sel)
	);

	spi_host_model i_spi_host_model (
		.sclk_out      (sclk),
		.sync_n_out    (sync_n),
		.data_out      (serial_in),
		.serial_out_in (serial_out)
	);

	// --------------------------------------------------------------
	// Expected state
	// --------------------------------------------------------------
	task automatic model_word(input logic [23:0] w);
		logic [39:0] hit;
		logic [2:0]  up;
		logic [2:0]  lo;
		logic [15:0] op;
		hit = '0;
		up = w[21:19];
		lo = w[18:16];
		op = w[15:0];
		if (w[23:22] != 2'b00) begin
			for (int g = 0; g < 5; g++) begin
				if (up == 3'h0 && (lo == 3'h0 || lo == 3'(g + 1))) hit[g*8 +: 8] = 8'hff;
				if (up == 3'(g + 1)) hit[g*8 + lo] = 1'b1;
				if (up == 3'h6 || (up == 3'h7 && g > 0)) hit[g*8 + lo] = 1'b1;
			end
			for (int c = 0; c < 40; c++) begin
				if (hit[c]) begin
					case (w[23:22])
						2'b11: if (e_ctrl.bank_sel) e_second[c] = w[15:2]; else e_first[c] = w[15:2];
						2'b10: e_ofs[c] = w[15:2];
						default: e_gain[c] = w[15:2];
					endcase
				end
			end
		end else begin
			case (w[21:16])
				6'h01: e_ctrl[2:0] = op[2:0];
				6'h02, 6'h03, 6'h04: e_odac[int'(w[21:16]) - 2] = op[13:0];
				6'h06, 6'h07, 6'h08, 6'h09, 6'h0a: e_bank[int'(w[21:16]) - 6] = op[7:0];
				6'h0b: e_bank = {5{op[7:0]}};
				default: ;
			endcase
		end
	endtask

	task automatic check_all();
		`CHK(bank_first, e_first)
		`CHK(bank_second, e_second)
		`CHK(ofs_reg, e_ofs)
		`CHK(gain_reg, e_gain)
		`CHK(ctrl, e_ctrl)
		`CHK(odac0, e_odac[0])
		`CHK(odac1, e_odac[1])
		`CHK(odac2, e_odac[2])
		`CHK(bank_sel, e_bank)
	endtask

	// --------------------------------------------------------------
	// Transfers
	// --------------------------------------------------------------
	task automatic xfer(input logic [23:0] w, input int n);
		i_spi_host_model.send_frame(w, n, pause, rd);
		if (n == 24) begin
			model_word(w);
		end
		check_all();
	endtask

	task automatic wr(input logic [1:0] m, input logic [5:0] a, input logic [13:0] d);
		xfer({m, a, d, 2'b00}, 24);
	endtask

	task automatic sf(input logic [5:0] f, input logic [15:0] op);
		xfer({2'b00, f, op}, 24);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_single();
		for (int m = 1; m < 4; m++) begin
			wr(2'(m), 6'h13, 14'h01a5 + 14'(m));
		end
		wr(2'b11, 6'h08, 14'h3fff);
		wr(2'b01, 6'h2f, 14'h0001);
	endtask

	task automatic t_group();
		wr(2'b01, 6'h00, 14'h0abc);
		for (int g = 1; g < 6; g++) begin
			wr(2'b10, 6'(g), 14'h0100 + 14'(g));
		end
		wr(2'b11, 6'h06, 14'h3333);
		wr(2'b11, 6'h07, 14'h3333);
		wr(2'b11, 6'h35, 14'h2222);
		wr(2'b01, 6'h32, 14'h0777);
		wr(2'b10, 6'h3f, 14'h1111);
	endtask

	task automatic t_control();
		@(posedge ref_clk_in);
		overtemp_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		e_ctrl.overtemp = 1'b1;
		check_all();
		sf(6'h01, 16'h0005);
		wr(2'b11, 6'h1a, 14'h2468);
		sf(6'h01, 16'h0002);
		@(posedge ref_clk_in);
		overtemp_in <= 1'b0;
		e_ctrl.overtemp = 1'b0;
		wr(2'b11, 6'h1a, 14'h1357);
	endtask

	task automatic t_special();
		for (int f = 2; f < 5; f++) begin
			sf(6'(f), 16'hf0a5 + 16'(f));
		end
		for (int f = 6; f < 11; f++) begin
			sf(6'(f), 16'hff10 + 16'(f));
		end
		sf(6'h0b, 16'h00ff);
		sf(6'h0b, 16'hff00);
		sf(6'h00, 16'h0000);
		sf(6'h1c, 16'h1234);
		sf(6'h0c, 16'hffff);
	endtask

	task automatic t_frames();
		xfer({2'b11, 6'h13, 14'h0f0f, 2'b00}, 23);
		xfer({2'b11, 6'h13, 14'h0f0f, 2'b00}, 25);
		pause = 37;
		wr(2'b10, 6'h13, 14'h0f0f);
		pause = 0;
	endtask

	task automatic rb(input logic [15:0] sel, input logic [15:0] exp);
		sf(6'h05, sel);
		`CHK(serial_oe, 1'b1)
		sf(6'h00, 16'h0000);
		`CHK(rd, {8'h00, exp})
		`CHK(serial_oe, 1'b0)
	endtask

	task automatic t_readback();
		rb({3'h4, 6'h03, 7'h00}, {2'b00, e_odac[1]});
		rb({3'h2, 6'h13, 7'h00}, {2'b00, e_ofs[11]});
		rb({3'h3, 6'h2f, 7'h00}, {2'b00, e_gain[39]});
		rb({3'h1, 6'h1a, 7'h00}, {2'b00, e_second[18]});
		rb({3'h4, 6'h01, 7'h00}, {11'h000, e_ctrl.overtemp, 1'b0, e_ctrl[2:0]});
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// Run
	// --------------------------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	// A hung frame would otherwise stall the run for good.
	initial begin
		#2000000;
		err_total++;
		stop_test();
	end

	initial begin
		resetn_in = 1'b0;
		overtemp_in = 1'b0;
		err_total = 0;
		samples_checked = 0;
		pause = 0;
		e_first = '0;
		e_second = '0;
		e_ofs = {`CH_COUNT{`RST_OFFSET}};
		e_gain = {`CH_COUNT{`RST_GAIN}};
		e_ctrl = '0;
		e_odac = '{`RST_OFSDAC, `RST_OFSDAC, `RST_OFSDAC};
		e_bank = '0;
		repeat (8) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		check_all();
		`CHK(serial_oe, 1'b0)
		t_single();
		t_group();
		t_control();
		t_special();
		t_frames();
		t_readback();
		stop_test();
	end

endmodule // dac_serial_command_decoder_tb

// ==== verif/spi_host_model.sv ====
// Purpose: Behavioural serial host that frames command words for the decoder.
// Assumes: Link clock idles high and runs only inside frames, 48 ns period when slow is zero.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/100ps

module spi_host_model (
	// Link outputs
	output logic       sclk_out,
	output logic       sync_n_out,
	output logic       data_out,
	// Readback input
	input  wire logic  serial_out_in
);

	initial begin
		sclk_out   = 1'b1;
		sync_n_out = 1'b1;
		data_out   = 1'b0;
	end

	// --------------------------------------------------------------
	// Frame transfer
	// --------------------------------------------------------------
	// A count other than 24 is only for frames meant to be refused.
	task automatic send_frame(input logic [23:0] word, input int n_clk, input int slow,
		output logic [23:0] rd);
		rd = 24'h000000;
		sync_n_out = 1'b0;
		#(24 + slow);
		for (int i = 0; i < n_clk; i++) begin
			data_out = (i < 24) ? word[23 - i] : ~data_out;
			#24 sclk_out = 1'b0;
			#24 sclk_out = 1'b1;
			if (i < 24) begin
				rd[23 - i] = serial_out_in;
			end
			#(slow);
		end
		#24 sync_n_out = 1'b1;
		data_out = ~data_out;
		// The idle gap keeps sync high well past the four system cycles needed.
		#(200 + slow);
	endtask

endmodule // spi_host_model
